/* core/sram_port_pkg.sv */
package sram_port_pkg;

	// ==========================================================
	// Data and address organisation
	localparam int LANE_W        = 9;
	localparam int DATA_W_NARROW = 18;
	localparam int DATA_W_WIDE   = 36;
	localparam int ADDR_W_NARROW = 22;
	localparam int ADDR_W_WIDE   = 21;

	// ==========================================================
	// Read latency in input-clock cycles
	localparam int RD_LAT_PLL    = 2;
	localparam int RD_LAT_LEGACY = 1;

	// ==========================================================
	// Strap values and reset values
	localparam logic TERM_RANGE_LOW   = 1'b0;
	localparam logic TERM_RANGE_HIGH  = 1'b1;
	localparam logic TERM_RANGE_RESET = 1'b1;
	localparam logic PLL_ON_LEVEL     = 1'b1;
	localparam logic SEL_ACTIVE       = 1'b0;
	localparam logic LANE_KEEP        = 1'b1;

endpackage : sram_port_pkg

/* core/lane_sync.sv */
`timescale 1ns/1ps

// Two flip-flop level synchroniser; only the second stage leaves the module
module lane_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = async_i;
		sync_d = meta_q;
	end

	always_ff @(posedge clk_i) begin
		meta_q <= meta_d;
		sync_q <= sync_d;
	end

	assign sync_o = sync_q;

endmodule : lane_sync

/* core/burst_mem.sv */
`timescale 1ns/1ps

// ==========================================================
// Two arrays, one word of each burst in each, lane-masked write
module burst_mem #(
	parameter int WORD_W = 18,
	parameter int LANES  = 2,
	parameter int ADDR_W = 22
) (
	input  wire logic              clk_i,
	input  wire logic              we_i,
	input  wire logic [ADDR_W-1:0] waddr_i,
	input  wire logic [WORD_W-1:0] wdata0_i,
	input  wire logic [WORD_W-1:0] wdata1_i,
	input  wire logic [LANES-1:0]  wlane0_n_i,
	input  wire logic [LANES-1:0]  wlane1_n_i,
	input  wire logic              re_i,
	input  wire logic [ADDR_W-1:0] raddr_i,
	output logic      [WORD_W-1:0] rdata0_o,
	output logic      [WORD_W-1:0] rdata1_o
);

	localparam int LW = sram_port_pkg::LANE_W;

	logic [WORD_W-1:0] arr0 [2**ADDR_W];
	logic [WORD_W-1:0] arr1 [2**ADDR_W];
	logic [WORD_W-1:0] rd0_q;
	logic [WORD_W-1:0] rd1_q;

	initial begin
		if (WORD_W != LANES * LW) begin
			$error("burst_mem: word width must be whole lanes");
		end
	end

	// Lanes whose select is high keep the stored byte
	always_ff @(posedge clk_i) begin
		for (int l = 0; l < LANES; l++) begin
			if (we_i && wlane0_n_i[l] != sram_port_pkg::LANE_KEEP) begin
				arr0[waddr_i][l*LW +: LW] <= wdata0_i[l*LW +: LW];
			end
			if (we_i && wlane1_n_i[l] != sram_port_pkg::LANE_KEEP) begin
				arr1[waddr_i][l*LW +: LW] <= wdata1_i[l*LW +: LW];
			end
		end
		if (re_i) begin
			rd0_q <= arr0[raddr_i];
			rd1_q <= arr1[raddr_i];
		end
	end

	assign rdata0_o = rd0_q;
	assign rdata1_o = rd1_q;

endmodule : burst_mem

/* core/ddr_burst2_sram_port.sv */
// Contract
// - Write data taken on both clock edges
// - Low write select starts write, high ignores
// - High byte-lane select leaves stored lane unchanged
// - Each lane select covers one 9-bit lane
// - Read address positive edge, write address negative
// - Address 22 or 21 bits, burst location
// - Deselected port address causes no access
// - Read data on both edges, tri-state deselected; rdata_o stays driven here, only rdata_oe_o drops
// - Low read select starts read, high deselects
// - Read completes, drivers off after next edge
// - Every read is exactly two-word burst
// - Valid flag high with data, echo aligned
// - Termination range latched at power-up init
// - Accesses start on positive clock edge
// - PLL disabled gives single-cycle legacy latency
// - Echo clocks free-running, follow input clock
`timescale 1ns/1ps

module ddr_burst2_sram_port #(
	parameter int DATA_W = sram_port_pkg::DATA_W_NARROW,
	parameter int ADDR_W = (DATA_W == sram_port_pkg::DATA_W_NARROW) ?
		sram_port_pkg::ADDR_W_NARROW : sram_port_pkg::ADDR_W_WIDE,
	parameter int LANES  = DATA_W / sram_port_pkg::LANE_W
) (
	input  wire logic              core_clk_i,
	input  wire logic              nrst_i,
	input  wire logic              k_clk_i,
	input  wire logic              write_port_select_n_i,
	input  wire logic              read_port_select_n_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic [LANES-1:0]  byte_lane_write_n_i,
	input  wire logic              pll_disable_n_i,
	input  wire logic              termination_range_sel_i,
	output logic      [DATA_W-1:0] rdata_o,
	output logic                   rdata_oe_o,
	output logic                   output_valid_flag_o,
	output logic                   echo_clk_o,
	output logic                   echo_clk_n_o,
	output logic                   term_range_high_o,
	output logic                   term_range_valid_o,
	output logic                   wr_event_o,
	output logic                   rd_event_o
);

	initial begin
		if (DATA_W != sram_port_pkg::DATA_W_NARROW && DATA_W != sram_port_pkg::DATA_W_WIDE) begin
			$error("ddr_burst2_sram_port: DATA_W must be 18 or 36");
		end
		if (LANES * sram_port_pkg::LANE_W != DATA_W || ADDR_W < 1) begin
			$error("ddr_burst2_sram_port: bad lane count or address width");
		end
		if (ADDR_W > ((DATA_W == sram_port_pkg::DATA_W_NARROW) ?
			sram_port_pkg::ADDR_W_NARROW : sram_port_pkg::ADDR_W_WIDE)) begin
			$error("ddr_burst2_sram_port: address wider than the array organisation");
		end
		// The registered read address adds exactly one cycle when the PLL is on
		if (sram_port_pkg::RD_LAT_PLL != sram_port_pkg::RD_LAT_LEGACY + 1) begin
			$error("ddr_burst2_sram_port: latency constants do not fit the pipeline");
		end
	end

	// Both ports decode their select the same way
	function automatic logic port_selected(input logic sel_n);
		return sel_n == sram_port_pkg::SEL_ACTIVE;
	endfunction : port_selected

	// ==========================================================
	// Core domain: reset source, termination strap, event pulses
	logic core_rst_n_q;
	logic core_rst_n_d;
	logic term_sync;
	logic term_done_q;
	logic term_done_d;
	logic term_high_q;
	logic term_high_d;
	logic wr_tgl_sync;
	logic rd_tgl_sync;
	logic wr_seen_q;
	logic wr_seen_d;
	logic rd_seen_q;
	logic rd_seen_d;
	logic wr_ev_q;
	logic wr_ev_d;
	logic rd_ev_q;
	logic rd_ev_d;
	// Link-side command toggles, read here by the event synchroniser
	logic wr_tgl_q;
	logic wr_tgl_d;
	logic rd_tgl_q;
	logic rd_tgl_d;

	lane_sync #(.W(1)) u_term_sync (
		.clk_i   (core_clk_i),
		.async_i (termination_range_sel_i),
		.sync_o  (term_sync)
	);

	lane_sync #(.W(2)) u_evt_sync (
		.clk_i   (core_clk_i),
		.async_i ({wr_tgl_q, rd_tgl_q}),
		.sync_o  ({wr_tgl_sync, rd_tgl_sync})
	);

	always_comb begin
		core_rst_n_d = 1'b1;
		term_done_d  = term_done_q;
		term_high_d  = term_high_q;
		// Strap caught once, two cycles after release so the sync has settled
		if (core_rst_n_q && !term_done_q) begin
			term_done_d = 1'b1;
			term_high_d = (term_sync == sram_port_pkg::TERM_RANGE_LOW) ?
				sram_port_pkg::TERM_RANGE_LOW : sram_port_pkg::TERM_RANGE_HIGH;
		end
		// A toggle level lasts a whole link cycle, so the faster core clock sees each change
		wr_seen_d = wr_tgl_sync;
		rd_seen_d = rd_tgl_sync;
		wr_ev_d   = wr_tgl_sync ^ wr_seen_q;
		rd_ev_d   = rd_tgl_sync ^ rd_seen_q;
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			core_rst_n_q <= 1'b0;
			term_done_q  <= 1'b0;
			term_high_q  <= sram_port_pkg::TERM_RANGE_RESET;
			wr_seen_q    <= 1'b0;
			rd_seen_q    <= 1'b0;
			wr_ev_q      <= 1'b0;
			rd_ev_q      <= 1'b0;
		end else begin
			core_rst_n_q <= core_rst_n_d;
			term_done_q  <= term_done_d;
			term_high_q  <= term_high_d;
			wr_seen_q    <= wr_seen_d;
			rd_seen_q    <= rd_seen_d;
			wr_ev_q      <= wr_ev_d;
			rd_ev_q      <= rd_ev_d;
		end
	end

	assign term_range_high_o  = term_high_q;
	assign term_range_valid_o = term_done_q;
	assign wr_event_o         = wr_ev_q;
	assign rd_event_o         = rd_ev_q;

	// ==========================================================
	// Link domain: reset and mode brought across
	// Link logic leaves reset only once the core reset has crossed
	logic link_rst_n;
	logic pll_on;
	logic legacy;

	lane_sync #(.W(2)) u_link_sync (
		.clk_i   (k_clk_i),
		.async_i ({core_rst_n_q, pll_disable_n_i}),
		.sync_o  ({link_rst_n, pll_on})
	);

	assign legacy = (pll_on != sram_port_pkg::PLL_ON_LEVEL);

	// Echo clocks simply follow the input clock and never stop
	assign echo_clk_o   = k_clk_i;
	assign echo_clk_n_o = ~k_clk_i;

	// ==========================================================
	// Positive-edge capture and read pipeline
	logic              rd_v_q;
	logic              rd_v_d;
	logic              rd_v2_q;
	logic              rd_v2_d;
	logic [ADDR_W-1:0] rd_addr_q;
	logic [ADDR_W-1:0] rd_addr_d;
	logic              wr_v_q;
	logic              wr_v_d;
	logic [DATA_W-1:0] wd0_q;
	logic [DATA_W-1:0] wd0_d;
	logic [LANES-1:0]  wl0_q;
	logic [LANES-1:0]  wl0_d;
	logic              oe_q;
	logic              oe_d;
	logic [DATA_W-1:0] q_pos_q;
	logic [DATA_W-1:0] q_pos_d;
	logic [DATA_W-1:0] q_hold_q;
	logic [DATA_W-1:0] q_hold_d;
	logic [DATA_W-1:0] mem_rd0;
	logic [DATA_W-1:0] mem_rd1;
	logic              mem_re;
	logic [ADDR_W-1:0] mem_raddr;

	// Negative-edge state, declared here for the write commit and the output beat
	logic [ADDR_W-1:0] wr_addr_q;
	logic [ADDR_W-1:0] wr_addr_d;
	logic [DATA_W-1:0] wd1_q;
	logic [DATA_W-1:0] wd1_d;
	logic [LANES-1:0]  wl1_q;
	logic [LANES-1:0]  wl1_d;
	logic [DATA_W-1:0] q_neg_q;
	logic [DATA_W-1:0] q_neg_d;

	always_comb begin
		rd_v_d    = port_selected(read_port_select_n_i);
		wr_v_d    = port_selected(write_port_select_n_i);
		rd_addr_d = rd_v_d ? addr_i : rd_addr_q;
		wd0_d     = wr_v_d ? wdata_i : wd0_q;
		// Idle cycles default every lane to keep, so nothing stale is stored
		wl0_d     = wr_v_d ? byte_lane_write_n_i : {LANES{sram_port_pkg::LANE_KEEP}};
		rd_v2_d   = rd_v_q;
		// Legacy mode reads one stage earlier, so the output stage needs no extra delay
		oe_d      = legacy ? rd_v_q : rd_v2_q;
		q_pos_d   = oe_d ? mem_rd0 : q_pos_q;
		q_hold_d  = oe_d ? mem_rd1 : q_hold_q;
		wr_tgl_d  = wr_v_q ? ~wr_tgl_q : wr_tgl_q;
		rd_tgl_d  = rd_v_q ? ~rd_tgl_q : rd_tgl_q;
	end

	always_ff @(posedge k_clk_i) begin
		if (!link_rst_n) begin
			rd_v_q    <= 1'b0;
			rd_v2_q   <= 1'b0;
			rd_addr_q <= '0;
			wr_v_q    <= 1'b0;
			wd0_q     <= '0;
			wl0_q     <= {LANES{sram_port_pkg::LANE_KEEP}};
			oe_q      <= 1'b0;
			q_pos_q   <= '0;
			q_hold_q  <= '0;
			wr_tgl_q  <= 1'b0;
			rd_tgl_q  <= 1'b0;
		end else begin
			rd_v_q    <= rd_v_d;
			rd_v2_q   <= rd_v2_d;
			rd_addr_q <= rd_addr_d;
			wr_v_q    <= wr_v_d;
			wd0_q     <= wd0_d;
			wl0_q     <= wl0_d;
			oe_q      <= oe_d;
			q_pos_q   <= q_pos_d;
			q_hold_q  <= q_hold_d;
			wr_tgl_q  <= wr_tgl_d;
			rd_tgl_q  <= rd_tgl_d;
		end
	end

	// ==========================================================
	// Negative-edge capture: write address, second beat, output beat
	always_comb begin
		wr_addr_d = wr_v_q ? addr_i : wr_addr_q;
		wd1_d     = wr_v_q ? wdata_i : wd1_q;
		wl1_d     = wr_v_q ? byte_lane_write_n_i : wl1_q;
		q_neg_d   = oe_q ? q_hold_q : q_neg_q;
	end

	always_ff @(negedge k_clk_i) begin
		if (!link_rst_n) begin
			wr_addr_q <= '0;
			wd1_q     <= '0;
			wl1_q     <= {LANES{sram_port_pkg::LANE_KEEP}};
			q_neg_q   <= '0;
		end else begin
			wr_addr_q <= wr_addr_d;
			wd1_q     <= wd1_d;
			wl1_q     <= wl1_d;
			q_neg_q   <= q_neg_d;
		end
	end

	// ==========================================================
	// Storage; write commits on the positive edge after the second beat
	// Legacy reads take the address straight from the pins to save a cycle
	// A read and a write to one address on one edge return the old word
	assign mem_re    = legacy ? port_selected(read_port_select_n_i) : rd_v_q;
	assign mem_raddr = legacy ? addr_i : rd_addr_q;

	burst_mem #(
		.WORD_W (DATA_W),
		.LANES  (LANES),
		.ADDR_W (ADDR_W)
	) u_mem (
		.clk_i      (k_clk_i),
		.we_i       (wr_v_q && link_rst_n),
		.waddr_i    (wr_addr_q),
		.wdata0_i   (wd0_q),
		.wdata1_i   (wd1_q),
		.wlane0_n_i (wl0_q),
		.wlane1_n_i (wl1_q),
		.re_i       (mem_re),
		.raddr_i    (mem_raddr),
		.rdata0_o   (mem_rd0),
		.rdata1_o   (mem_rd1)
	);

	// ==========================================================
	// Pins: first beat in the high phase, second in the low phase
	// The phase mux assumes a clean link clock; a glitch on it shows on the pins
	assign rdata_o             = k_clk_i ? q_pos_q : q_neg_q;
	assign rdata_oe_o          = oe_q;
	assign output_valid_flag_o = oe_q;

endmodule : ddr_burst2_sram_port

/* dv/sram_port_props.sv */
`timescale 1ns/1ps
// ==========================================================
// Port checks on the input clock and the core clock
module sram_port_props (
	input wire logic k_clk_i,
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic read_port_select_n_i,
	input wire logic pll_disable_n_i,
	input wire logic termination_range_sel_i,
	input wire logic rdata_oe_o,
	input wire logic output_valid_flag_o,
	input wire logic echo_clk_o,
	input wire logic echo_clk_n_o,
	input wire logic term_range_high_o,
	input wire logic term_range_valid_o
);
	a_valid_with_oe: assert property (@(posedge k_clk_i) disable iff (!nrst_i)
		output_valid_flag_o == rdata_oe_o) else $error("valid flag differs from enable");
	a_read_lat_pll: assert property (@(posedge k_clk_i) disable iff (!nrst_i)
		!read_port_select_n_i && pll_disable_n_i && $past(pll_disable_n_i, 4)
		|-> ##3 rdata_oe_o) else $error("read data late with pll on");
	a_read_lat_legacy: assert property (@(posedge k_clk_i) disable iff (!nrst_i)
		!read_port_select_n_i && !pll_disable_n_i && !$past(pll_disable_n_i, 4)
		|-> ##2 rdata_oe_o) else $error("read data late in legacy mode");
	a_burst_one_cycle: assert property (@(posedge k_clk_i) disable iff (!nrst_i)
		(!read_port_select_n_i && pll_disable_n_i) ##1 read_port_select_n_i
		|-> ##2 rdata_oe_o ##1 !rdata_oe_o) else $error("burst length wrong");
	a_oe_drops: assert property (@(posedge k_clk_i) disable iff (!nrst_i)
		read_port_select_n_i [*3] |=> !rdata_oe_o) else $error("output not released");
	a_oe_cause: assert property (@(posedge k_clk_i) disable iff (!nrst_i)
		$rose(rdata_oe_o) |-> !$past(read_port_select_n_i, 2) || !$past(read_port_select_n_i, 3))
		else $error("output enabled without a read");
	a_echo_pair: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		echo_clk_o == k_clk_i && echo_clk_n_o == !k_clk_i) else $error("echo clock wrong");
	a_term_value: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		term_range_valid_o |-> term_range_high_o == termination_range_sel_i)
		else $error("termination range wrong");
endmodule : sram_port_props

bind ddr_burst2_sram_port sram_port_props u_props (
	.k_clk_i                (k_clk_i),
	.core_clk_i             (core_clk_i),
	.nrst_i                 (nrst_i),
	.read_port_select_n_i   (read_port_select_n_i),
	.pll_disable_n_i        (pll_disable_n_i),
	.termination_range_sel_i(termination_range_sel_i),
	.rdata_oe_o             (rdata_oe_o),
	.output_valid_flag_o    (output_valid_flag_o),
	.echo_clk_o             (echo_clk_o),
	.echo_clk_n_o           (echo_clk_n_o),
	.term_range_high_o      (term_range_high_o),
	.term_range_valid_o     (term_range_valid_o)
);

/* dv/sram_ctrl_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Controller side: commands on the input clock, capture on echo
module sram_ctrl_model #(
	parameter int DW = 18,
	parameter int AW = 8
) (
	input  wire logic            k_clk_i,
	input  wire logic            echo_clk_i,
	input  wire logic [DW-1:0]   rdata_i,
	input  wire logic            oe_i,
	output logic                 wr_sel_n_o,
	output logic                 rd_sel_n_o,
	output logic      [AW-1:0]   addr_o,
	output logic      [DW-1:0]   wdata_o,
	output logic      [DW/9-1:0] lane_n_o
);
	initial begin
		wr_sel_n_o = 1'b1;
		rd_sel_n_o = 1'b1;
		addr_o     = '0;
		wdata_o    = '0;
		lane_n_o   = '1;
	end
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] b0, b1,
		input logic [DW/9-1:0] l0, l1);
		@(posedge k_clk_i);
		wr_sel_n_o <= 1'b0;
		wdata_o    <= b0;
		lane_n_o   <= l0;
		// Second beat and write address stand over the falling edge that follows
		@(posedge k_clk_i);
		wr_sel_n_o <= 1'b1;
		addr_o     <= a;
		wdata_o    <= b1;
		lane_n_o   <= l1;
		@(posedge k_clk_i);
		// Released lines show the inverse so stale values cannot pass
		addr_o   <= ~a;
		wdata_o  <= ~b1;
		lane_n_o <= ~l1;
	endtask : wr
	task automatic rd(input logic [AW-1:0] a, input int lat,
		output logic v, output logic [DW-1:0] q0, q1, output logic off);
		@(posedge k_clk_i);
		rd_sel_n_o <= 1'b0;
		addr_o     <= a;
		@(posedge k_clk_i);
		rd_sel_n_o <= 1'b1;
		addr_o     <= ~a;
		// Step past this edge so its own echo edge is not counted
		#1;
		repeat (lat) @(posedge echo_clk_i);
		#1;
		v  = oe_i;
		q0 = rdata_i;
		@(negedge echo_clk_i);
		#1;
		q1 = rdata_i;
		@(posedge echo_clk_i);
		#1;
		off = oe_i;
	endtask : rd
endmodule : sram_ctrl_model

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
	localparam int DW = sram_port_pkg::DATA_W_NARROW;
	localparam int AW = 8;
	logic          core_clk, k_clk, nrst, pll_n, term_sel, wr_sel_n, rd_sel_n;
	logic          oe, valid, echo, echo_n, term_hi, term_ok, wr_ev, rd_ev;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata, rdata;
	logic [1:0]    lane_n;
	int            err_count, n_compared;
	int            n_wr = 0;
	int            n_rd = 0;
	int            cycles = 0;

	ddr_burst2_sram_port #(.DATA_W(DW), .ADDR_W(AW)) DUT (.core_clk_i(core_clk),
		.nrst_i(nrst), .k_clk_i(k_clk), .write_port_select_n_i(wr_sel_n),
		.read_port_select_n_i(rd_sel_n), .addr_i(addr), .wdata_i(wdata),
		.byte_lane_write_n_i(lane_n), .pll_disable_n_i(pll_n),
		.termination_range_sel_i(term_sel), .rdata_o(rdata), .rdata_oe_o(oe),
		.output_valid_flag_o(valid), .echo_clk_o(echo), .echo_clk_n_o(echo_n),
		.term_range_high_o(term_hi), .term_range_valid_o(term_ok),
		.wr_event_o(wr_ev), .rd_event_o(rd_ev));
	sram_ctrl_model #(.DW(DW), .AW(AW)) u_ctl (.k_clk_i(k_clk), .echo_clk_i(echo),
		.rdata_i(rdata), .oe_i(valid), .wr_sel_n_o(wr_sel_n), .rd_sel_n_o(rd_sel_n),
		.addr_o(addr), .wdata_o(wdata), .lane_n_o(lane_n));

	// Event pulses counted away from the core edge that launches them
	always @(negedge core_clk) begin
		if (wr_ev === 1'b1) begin
			n_wr++;
		end
		if (rd_ev === 1'b1) begin
			n_rd++;
		end
	end

	// ==========================================================
	// Compare and closing tasks
	task automatic cmp_d(input logic [DW-1:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t data %h expected %h", $time, got, exp);
		end
	endtask : cmp_d
	task automatic cmp_b(input logic got, exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : cmp_b
	task automatic cmp_n(input int got, exp);
		n_compared++;
		if (got != exp) begin
			err_count++;
			$display("[ERR] %0t count %0d expected %0d", $time, got, exp);
		end
	endtask : cmp_n
	task automatic close_out;
		if (err_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		repeat (9) @(posedge core_clk);
		#1;
		cmp_b(oe, 1'b0);
		cmp_b(term_hi, sram_port_pkg::TERM_RANGE_RESET);
		cmp_b(term_ok, 1'b0);
		@(posedge core_clk);
		nrst <= 1'b1;
		repeat (8) @(posedge k_clk);
		cmp_b(term_ok, 1'b1);
		cmp_b(term_hi, sram_port_pkg::TERM_RANGE_LOW);
	endtask : t_reset
	task automatic t_rw(input logic [AW-1:0] a, input logic [DW-1:0] b0, b1, input int lat);
		logic          v, off;
		logic [DW-1:0] q0, q1;
		u_ctl.wr(a, b0, b1, 2'b00, 2'b00);
		u_ctl.rd(a, lat, v, q0, q1, off);
		cmp_b(v, 1'b1);
		cmp_d(q0, b0);
		cmp_d(q1, b1);
		cmp_b(off, 1'b0);
	endtask : t_rw
	task automatic t_lanes;
		logic          v, off;
		logic [DW-1:0] q0, q1;
		u_ctl.wr(8'h33, 18'h3ffff, 18'h3ffff, 2'b00, 2'b00);
		u_ctl.wr(8'h33, 18'h00000, 18'h00000, 2'b01, 2'b10);
		u_ctl.rd(8'h33, 2, v, q0, q1, off);
		cmp_d(q0, 18'h001ff);
		cmp_d(q1, 18'h3fe00);
		// Earlier location untouched by the traffic above
		u_ctl.rd(8'h12, 2, v, q0, q1, off);
		cmp_d(q0, 18'h2a5c3);
		cmp_d(q1, 18'h15a3c);
	endtask : t_lanes
	task automatic t_legacy;
		@(posedge core_clk);
		pll_n <= 1'b0;
		repeat (4) @(posedge k_clk);
		t_rw(8'hff, 18'h3ffff, 18'h00001, sram_port_pkg::RD_LAT_LEGACY);
		@(posedge core_clk);
		pll_n <= 1'b1;
	endtask : t_legacy
	// Four writes and four reads were issued by the scenarios above
	task automatic t_events;
		repeat (10) @(posedge core_clk);
		cmp_n(n_wr, 4);
		cmp_n(n_rd, 4);
	endtask : t_events

	initial begin
		core_clk = 1'b0;
		k_clk = 1'b0;
		nrst = 1'b0;
		pll_n = sram_port_pkg::PLL_ON_LEVEL;
		term_sel = sram_port_pkg::TERM_RANGE_LOW;
		err_count = 0;
		n_compared = 0;
		t_reset();
		t_rw(8'h12, 18'h2a5c3, 18'h15a3c, sram_port_pkg::RD_LAT_PLL);
		t_lanes();
		t_legacy();
		t_events();
		close_out();
	end
	always #12.5 core_clk = ~core_clk;
	// Link clock period 48 ns, free running like the echo it produces
	always #24 k_clk = ~k_clk;
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			err_count++;
			close_out();
		end
	end
endmodule : testbench
